// [verilog/ce_crc_engine.sv]
// CRC engine with AHB-Lite registers and peripheral bus snooping
//
// Summary of operation
// - In 32-bit width the CRC uses the fixed polynomial 0x04C11DB7.
// - In 16-bit width the polynomial comes from a writable 16-bit register.
// - An input option reverses the bit order inside each byte of data.
// - An input option reverses the byte order of each incoming block.
// - The result may be read bit-reversed over the word or per half-word.
// - One control write sets the configuration and seeds the CRC.
// - A whole 32, 16 or 8 bit block is folded in one clock cycle.
// - A new 32-bit word can be taken on every clock cycle.
// - With snooping on, bus writes, or bus reads if so chosen, to one chosen peripheral feed the CRC.
// - Each word written to the data register updates the running CRC.
// - DMA writes to the data register are taken like firmware writes.
`timescale 1ns/1ps
module ce_crc_engine
  import ce_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic snp_psel,
  input wire logic snp_penable,
  input wire logic snp_pwrite,
  input wire logic snp_pready,
  input wire logic [31:0] snp_paddr,
  input wire logic [31:0] snp_pwdata,
  input wire logic [31:0] snp_prdata
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic wide;
    logic in_rev;
    logic in_swap;
    ce_orev_t orev;
    ce_blk_t blk;
    logic [15:0] poly;
    logic [31:0] crc;
    logic snoop_en;
    logic snoop_rd;
    logic [21:0] snoop_base;
    logic [31:0] count;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_off;
    logic rd_done;
    logic [31:0] rdata;
  } ce_state_t;

  ce_state_t s_q;
  ce_state_t s_d;

  localparam ce_state_t CE_STATE_RST = '{
    wide: 1'b1,
    in_rev: 1'b0,
    in_swap: 1'b0,
    orev: CE_OREV_NONE,
    blk: CE_BLK_32,
    poly: CE_POLY16_RST,
    crc: CE_SEED_ONES,
    snoop_en: 1'b0,
    snoop_rd: 1'b0,
    snoop_base: 22'h000000,
    count: CE_ZERO32,
    dp_valid: 1'b0,
    dp_write: 1'b0,
    dp_off: 8'h00,
    rd_done: 1'b0,
    rdata: CE_ZERO32
  };

  // ------------------------------------------------------------
  // Bus phase decode
  // ------------------------------------------------------------
  logic addr_take;
  logic wr_phase;
  logic rd_phase;
  logic snoop_hit;
  logic [31:0] snoop_word;
  logic data_wr;
  logic stall;

  assign addr_take = hsel && htrans == CE_HTRANS_NONSEQ && hready;
  assign wr_phase = s_q.dp_valid && s_q.dp_write;
  assign rd_phase = s_q.dp_valid && !s_q.dp_write;

  // Snoop: completed transfer in the chosen peripheral window
  assign snoop_hit = s_q.snoop_en && snp_psel && snp_penable &&
                     snp_pready && (snp_pwrite != s_q.snoop_rd) &&
                     snp_paddr[CE_SNOOP_MSB:CE_SNOOP_LSB] ==
                     s_q.snoop_base;
  assign snoop_word = snp_pwrite ? snp_pwdata : snp_prdata;

  // A data register write that meets a snooped word waits one cycle
  assign data_wr = wr_phase && s_q.dp_off == CE_OFF_DATA;
  assign stall = data_wr && snoop_hit;

  // Writes finish at once except a stalled data write, reads after one wait cycle
  assign hreadyout = !s_q.dp_valid ||
                     (s_q.dp_write ? !stall : s_q.rd_done);
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  logic [31:0] in_word;
  logic [31:0] in_rev;
  logic [31:0] in_sw;
  logic [31:0] fold_in;
  logic [31:0] fold_out;
  logic fold_go;

  assign fold_go = snoop_hit || data_wr;
  assign in_word = snoop_hit ? snoop_word : hwdata;

  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_inrev
      assign in_rev[b] = s_q.in_rev ?
                         in_word[(b & ~7) | (7 - (b & 7))] :
                         in_word[b];
    end
  endgenerate

  always_comb begin
    in_sw = in_rev;
    if (s_q.in_swap) begin
      case (s_q.blk)
        CE_BLK_16: begin
          in_sw = {in_rev[31:16], in_rev[7:0], in_rev[15:8]};
        end
        CE_BLK_8: begin
          in_sw = in_rev;
        end
        default: begin
          in_sw = {in_rev[7:0], in_rev[15:8],
                   in_rev[23:16], in_rev[31:24]};
        end
      endcase
    end
  end

  assign fold_in = in_sw;

  ce_crc_fold u_fold (
    .crc_in(s_q.crc),
    .data_in(fold_in),
    .blk(s_q.blk),
    .wide(s_q.wide),
    .poly16(s_q.poly),
    .crc_out(fold_out)
  );

  // ------------------------------------------------------------
  // Result view
  // ------------------------------------------------------------
  logic [31:0] crc_view;
  logic [31:0] rev_word;
  logic [31:0] rev_half;

  generate
    for (b = 0; b < 32; b++) begin : g_orev
      assign rev_word[b] = s_q.crc[31 - b];
      assign rev_half[b] = s_q.crc[(b & 16) | (15 - (b & 15))];
    end
  endgenerate

  always_comb begin
    case (s_q.orev)
      CE_OREV_WORD: begin
        crc_view = rev_word;
      end
      CE_OREV_HALF: begin
        crc_view = rev_half;
      end
      default: begin
        crc_view = s_q.crc;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [31:0] ctrl_rd;
  logic [31:0] read_val;

  always_comb begin
    ctrl_rd = CE_ZERO32;
    ctrl_rd[CE_CTRL_WIDE] = s_q.wide;
    ctrl_rd[CE_CTRL_INREV] = s_q.in_rev;
    ctrl_rd[CE_CTRL_INSWAP] = s_q.in_swap;
    ctrl_rd[CE_CTRL_OREV_HI:CE_CTRL_OREV_LO] = s_q.orev;
    ctrl_rd[CE_CTRL_BLK_HI:CE_CTRL_BLK_LO] = s_q.blk;
  end

  always_comb begin
    if (s_q.dp_off == CE_OFF_CTRL) begin
      read_val = ctrl_rd;
    end else if (s_q.dp_off == CE_OFF_POLY) begin
      read_val = {16'h0000, s_q.poly};
    end else if (s_q.dp_off == CE_OFF_RESULT) begin
      read_val = crc_view;
    end else if (s_q.dp_off == CE_OFF_SNOOP) begin
      read_val = {30'h00000000, s_q.snoop_rd, s_q.snoop_en};
    end else if (s_q.dp_off == CE_OFF_SNBASE) begin
      read_val = {s_q.snoop_base, 10'h000};
    end else if (s_q.dp_off == CE_OFF_COUNT) begin
      read_val = s_q.count;
    end else begin
      read_val = CE_ZERO32;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [31:0] seed_val;

  always_comb begin
    s_d = s_q;
    seed_val = CE_ZERO32;

    // Fold one word per cycle from the data register or the snoop
    if (fold_go) begin
      s_d.crc = fold_out;
      s_d.count = s_q.count + 32'h00000001;
    end

    // Register writes in the data phase
    if (wr_phase && !stall) begin
      if (s_q.dp_off == CE_OFF_CTRL) begin
        s_d.wide = hwdata[CE_CTRL_WIDE];
        s_d.in_rev = hwdata[CE_CTRL_INREV];
        s_d.in_swap = hwdata[CE_CTRL_INSWAP];
        s_d.orev = ce_orev_t'(hwdata[CE_CTRL_OREV_HI:CE_CTRL_OREV_LO]);
        s_d.blk = ce_blk_t'(hwdata[CE_CTRL_BLK_HI:CE_CTRL_BLK_LO]);
        if (hwdata[CE_CTRL_SEED_SET]) begin
          seed_val = hwdata[CE_CTRL_SEED_ONES] ? CE_SEED_ONES :
                     CE_ZERO32;
          s_d.crc = hwdata[CE_CTRL_WIDE] ? seed_val :
                    (seed_val & CE_MASK16);
          s_d.count = CE_ZERO32;
        end
      end else if (s_q.dp_off == CE_OFF_POLY) begin
        s_d.poly = hwdata[15:0];
      end else if (s_q.dp_off == CE_OFF_RESULT) begin
        s_d.crc = s_q.wide ? hwdata : (hwdata & CE_MASK16);
        s_d.count = CE_ZERO32;
      end else if (s_q.dp_off == CE_OFF_SNOOP) begin
        s_d.snoop_en = hwdata[CE_SNOOP_EN];
        s_d.snoop_rd = hwdata[CE_SNOOP_RD];
      end else if (s_q.dp_off == CE_OFF_SNBASE) begin
        s_d.snoop_base = hwdata[CE_SNOOP_MSB:CE_SNOOP_LSB];
      end
    end

    // Read data is captured in the wait cycle
    s_d.rd_done = 1'b0;
    if (rd_phase && !s_q.rd_done) begin
      s_d.rdata = read_val;
      s_d.rd_done = 1'b1;
    end

    // Address phase tracking
    if (hreadyout) begin
      s_d.dp_valid = addr_take;
      s_d.dp_write = hwrite;
      s_d.dp_off = {haddr[7:2], 2'b00};
      s_d.rd_done = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= CE_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [shared/ce_pkg.sv]
// Constants, offsets and field layouts of the CRC engine
package ce_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CE_OFF_CTRL = 8'h00;
  localparam logic [7:0] CE_OFF_POLY = 8'h04;
  localparam logic [7:0] CE_OFF_DATA = 8'h08;
  localparam logic [7:0] CE_OFF_RESULT = 8'h0C;
  localparam logic [7:0] CE_OFF_SNOOP = 8'h10;
  localparam logic [7:0] CE_OFF_SNBASE = 8'h14;
  localparam logic [7:0] CE_OFF_COUNT = 8'h18;

  // ------------------------------------------------------------
  // Control and snoop register fields
  // ------------------------------------------------------------
  localparam int CE_CTRL_WIDE = 0;
  localparam int CE_CTRL_INREV = 1;
  localparam int CE_CTRL_INSWAP = 2;
  localparam int CE_CTRL_OREV_LO = 3;
  localparam int CE_CTRL_OREV_HI = 4;
  localparam int CE_CTRL_BLK_LO = 5;
  localparam int CE_CTRL_BLK_HI = 6;
  localparam int CE_CTRL_SEED_SET = 8;
  localparam int CE_CTRL_SEED_ONES = 9;
  localparam int CE_SNOOP_EN = 0;
  localparam int CE_SNOOP_RD = 1;
  localparam int CE_SNOOP_MSB = 31;
  localparam int CE_SNOOP_LSB = 10;

  // ------------------------------------------------------------
  // Encodings and fixed values
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CE_OREV_NONE,
    CE_OREV_WORD,
    CE_OREV_HALF,
    CE_OREV_RSVD
  } ce_orev_t;

  typedef enum logic [1:0] {
    CE_BLK_32,
    CE_BLK_16,
    CE_BLK_8,
    CE_BLK_RSVD
  } ce_blk_t;

  localparam logic [31:0] CE_POLY32 = 32'h04C11DB7;
  localparam logic [15:0] CE_POLY16_RST = 16'h1021;
  localparam logic [31:0] CE_SEED_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] CE_MASK16 = 32'h0000FFFF;
  localparam logic [31:0] CE_ZERO32 = 32'h00000000;
  localparam logic [1:0] CE_HTRANS_NONSEQ = 2'h2;

endpackage

// [verilog/ce_crc_fold.sv]
// Single-cycle unrolled CRC fold of a 32, 16 or 8 bit block
`timescale 1ns/1ps
module ce_crc_fold
  import ce_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_in,
  input wire ce_blk_t blk,
  input wire logic wide,
  input wire logic [15:0] poly16,
  output logic [31:0] crc_out
);

  // ------------------------------------------------------------
  // Block alignment, first bit at the top
  // ------------------------------------------------------------
  logic [31:0] aligned;
  logic [5:0] nbits;
  logic [31:0] stage [0:32];

  always_comb begin
    case (blk)
      CE_BLK_16: begin
        aligned = {data_in[15:0], 16'h0000};
        nbits = 6'h10;
      end
      CE_BLK_8: begin
        aligned = {data_in[7:0], 24'h000000};
        nbits = 6'h08;
      end
      default: begin
        aligned = data_in;
        nbits = 6'h20;
      end
    endcase
  end

  // ------------------------------------------------------------
  // One shift stage per bit, unused stages pass through
  // ------------------------------------------------------------
  assign stage[0] = crc_in;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      logic fb;
      logic [31:0] nxt;
      always_comb begin
        fb = (wide ? stage[i][31] : stage[i][15]) ^ aligned[31-i];
        if (wide) begin
          nxt = {stage[i][30:0], 1'b0} ^ (fb ? CE_POLY32 : CE_ZERO32);
        end else begin
          nxt = {16'h0000, stage[i][14:0], 1'b0} ^
                {16'h0000, (fb ? poly16 : 16'h0000)};
        end
      end
      assign stage[i+1] = (6'(i) < nbits) ? nxt : stage[i];
    end
  endgenerate

  assign crc_out = stage[32];

endmodule

// [testbench/ce_apb_agent.sv]
// Peripheral bus traffic seen by the snoop port
`timescale 1ns/1ps
module ce_apb_agent (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [21:0] base,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic pready = 1'b0,
  output logic [31:0] paddr = 32'h0,
  output logic [31:0] pwdata = 32'h0,
  output logic [31:0] prdata = 32'h0
);
  int s = 95403;
  always @(posedge clk) begin
    if (rst || !run || (penable && pready)) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pready <= 1'b0;
      pwdata <= ~pwdata;
      prdata <= ~prdata;
    end else if (!psel) begin
      psel <= 1'b1;
      pwrite <= 1'($random(s));
      paddr <= {base ^ 22'($random(s) & 1), 10'($random(s))};
      pwdata <= $random(s);
    end else begin
      penable <= 1'b1;
      pready <= 1'($random(s));
      prdata <= $random(s);
    end
  end
endmodule

// [testbench/ce_crc_engine_properties.sv]
// Bus timing checker for the CRC engine
`timescale 1ns/1ps
module ce_props
  import ce_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic snp_psel,
  input wire logic snp_penable,
  input wire logic snp_pready
);
  logic tk, dn, dp_q, rd_q, dw_q;
  assign tk = hsel && htrans == CE_HTRANS_NONSEQ && hready;
  assign dn = snp_psel && snp_penable && snp_pready;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {dp_q, rd_q, dw_q} <= 3'h0;
    end else if (hreadyout) begin
      dp_q <= tk;
      rd_q <= tk && !hwrite;
      dw_q <= tk && hwrite && haddr[7:0] == CE_OFF_DATA;
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd; tk && !hwrite; endsequence
  sequence s_wait1; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd |=> s_wait1; endproperty
  property p_wr_fast;
    tk && hwrite && haddr[7:0] != CE_OFF_DATA |=> hreadyout;
  endproperty
  property p_data_fast; dw_q && !dn |-> hreadyout; endproperty
  property p_why;
    !hreadyout |-> (rd_q && $past(hreadyout)) || (dw_q && dn);
  endproperty
  property p_idle; !dp_q |-> hreadyout; endproperty
  property p_stand;
    !$stable(hrdata) |-> $past(rd_q) && !$past(hreadyout);
  endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_snp_free; dn && !dp_q |-> hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait wrong");
  a_wr_fast: assert property (p_wr_fast)
    else $error("write stalled");
  a_data_fast: assert property (p_data_fast)
    else $error("data write stalled");
  a_why: assert property (p_why)
    else $error("stall without cause");
  a_idle: assert property (p_idle)
    else $error("not ready when idle");
  a_stand: assert property (p_stand)
    else $error("read data moved");
  a_okay: assert property (p_okay)
    else $error("error response");
  a_snp_free: assert property (p_snp_free)
    else $error("snoop stalled bus");
endmodule
bind ce_crc_engine ce_props u_props (.core_clk(core_clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .snp_psel(snp_psel), .snp_penable(snp_penable), .snp_pready(snp_pready));

// [testbench/test_crc_engine_with_bus_snoop.sv]
// Self-checking bench for the CRC engine
`timescale 1ns/1ps
module test_crc_engine_with_bus_snoop;
  import ce_pkg::*;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, run = 0;
  logic [1:0] htrans = 0, snc = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv, pa, pwd, prd, v;
  logic hreadyout, hresp, ps, pe, pw, pr;
  logic [21:0] base = 22'h0A5;
  logic [31:0] crc = CE_SEED_ONES, cnt = 0, poly = {16'h0, CE_POLY16_RST};
  logic [6:0] cf = 7'h01;
  int seed = 95403, fail_count = 0, compares = 0, cyc = 0;
  ce_crc_engine dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .snp_psel(ps), .snp_penable(pe),
    .snp_pwrite(pw), .snp_pready(pr), .snp_paddr(pa), .snp_pwdata(pwd),
    .snp_prdata(prd));
  ce_apb_agent apb_u (.clk(core_clk), .rst(rst), .run(run), .base(base),
    .psel(ps), .penable(pe), .pwrite(pw), .pready(pr), .paddr(pa),
    .pwdata(pwd), .prdata(prd));
  initial forever #10 core_clk = ~core_clk;
  // -----------------------
  // Model, bus and checking
  // -----------------------
  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d);
    logic [31:0] t;
    int nb;
    nb = cf[6:5] == 2'h1 ? 16 : (cf[6:5] == 2'h2 ? 8 : 32);
    for (int i = 0; i < 32; i++)
      t[i] = cf[1] ? d[i ^ 7] : d[i];
    d = t;
    if (cf[2] && nb == 32) d = {t[7:0], t[15:8], t[23:16], t[31:24]};
    if (cf[2] && nb == 16) d = {t[31:16], t[7:0], t[15:8]};
    for (int i = nb - 1; i >= 0; i--)
      if (cf[0]) c = {c[30:0], 1'b0} ^ (c[31] ^ d[i] ? CE_POLY32 : 0);
      else c = {16'h0, c[14:0], 1'b0} ^ (c[15] ^ d[i] ? poly : 0);
    return c;
  endfunction
  function automatic logic [31:0] view(logic [31:0] c);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = cf[4:3] == 2'h1 ? c[i ^ 31] : (cf[4:3] == 2'h2 ? c[i ^ 15] : c[i]);
    return r;
  endfunction
  task automatic sd(input logic [31:0] s);
    crc = cf[0] ? s : s & CE_MASK16;
    cnt = 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt();
    @(negedge core_clk);
    while (hreadyout !== 1'b1) @(negedge core_clk);
    rv = hrdata;
    @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= CE_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    if (w && a == CE_OFF_DATA) crc = fold(crc, d);
    if (w && a == CE_OFF_DATA) cnt++;
    if (w && a == CE_OFF_POLY) poly = d & CE_MASK16;
    if (w && a == CE_OFF_RESULT) sd(d);
    if (w && a == CE_OFF_SNOOP) snc = d[1:0];
    if (w && a == CE_OFF_CTRL) cf = d[6:0];
    if (w && a == CE_OFF_CTRL && d[8]) sd(d[9] ? CE_SEED_ONES : CE_ZERO32);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, CE_ZERO32);
    chk(rv, e);
    chk({31'h0, hresp}, CE_ZERO32);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(negedge core_clk)
    if (!rst && snc[0] && ps && pe && pr && pw != snc[1]
        && pa[31:10] == base) begin
      crc = fold(crc, pw ? pwd : prd);
      cnt++;
    end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(CE_OFF_RESULT, crc);
    rd(CE_OFF_POLY, poly);
    rd(8'h1C, CE_ZERO32);
    rd(CE_OFF_DATA, CE_ZERO32);
    rd(CE_OFF_CTRL, 32'h00000001);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, CE_OFF_POLY, $random(seed));
      v = ($random(seed) & 32'h207) | (k << 3) | (k[0] << 8);
      bus(1'b1, CE_OFF_CTRL, v);
      rd(CE_OFF_CTRL, v & 32'h0000007F);
      if (!k[0]) bus(1'b1, CE_OFF_RESULT, $random(seed));
      for (int j = 0; j <= k % 4; j++)
        bus(1'b1, CE_OFF_DATA, $random(seed));
      bus(1'b1, CE_OFF_COUNT, CE_SEED_ONES);
      rd(CE_OFF_RESULT, view(crc));
      rd(CE_OFF_RESULT, view(crc));
      rd(CE_OFF_COUNT, cnt);
    end
    $display("test modes done");
    bus(1'b1, CE_OFF_CTRL, 32'h301);
    bus(1'b1, CE_OFF_SNBASE, {base, 10'h0});
    rd(CE_OFF_SNBASE, {base, 10'h000});
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, CE_OFF_SNOOP, 1 + 2 * d);
      rd(CE_OFF_SNOOP, 1 + 2 * d);
      run <= 1'b1;
      repeat (24) bus(1'b1, CE_OFF_DATA, $random(seed));
      run <= 1'b0;
      repeat (3) @(posedge core_clk);
      bus(1'b1, CE_OFF_SNOOP, CE_ZERO32);
      rd(CE_OFF_RESULT, view(crc));
      rd(CE_OFF_COUNT, cnt);
    end
    $display("test snoop done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    crc = CE_SEED_ONES;
    cf = 7'h01;
    poly = {16'h0000, CE_POLY16_RST};
    cnt = 0;
    snc = 2'h0;
    @(posedge core_clk);
    rd(CE_OFF_RESULT, crc);
    rd(CE_OFF_POLY, poly);
    rd(CE_OFF_COUNT, cnt);
    rd(CE_OFF_CTRL, 32'h00000001);
    rd(CE_OFF_SNOOP, CE_ZERO32);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
